// file: cfg_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH a power of two
// Notes: Read data comes out of a register
`timescale 1ns/1ps
`default_nettype none
module cfg_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_st_t;
  fifo_st_t s, next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;
  assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
  assign empty = s.wp == s.rp;
  assign in_ready = !full;
  assign push = in_valid && !full;
  assign pop = !empty && (!s.ov || out_ready);
  assign out_valid = s.ov;
  assign out_data = s.od;
  always_comb begin
    next_s = s;
    if (push) next_s.wp = s.wp + 1'b1;
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
      next_s.od = mem[s.rp[AW-1:0]];
      next_s.ov = 1'b1;
    end else if (out_ready) begin
      next_s.ov = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) s <= '0;
    else s <= next_s;
    if (push) mem[s.wp[AW-1:0]] <= in_data;
  end
endmodule // cfg_fifo
`default_nettype wire

// file: config_loader_pkg.sv
// Purpose: Shared constants for the serial ROM configuration loader
// Assumes: 3-wire byte-organized serial memory, 9 address bits
// Notes: Link runs on its own clock, one bit per link clock edge
`default_nettype none
package config_loader_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam logic [7:0] SIG_BYTE = 8'ha5;
  localparam logic [8:0] SIG_OFF = 9'h000;
  localparam logic [8:0] MAC_FIRST = 9'h001;
  localparam logic [8:0] MAC_LAST = 9'h006;
  localparam logic [8:0] LOAD_LAST = 9'h039;
  localparam logic [8:0] LEN_FIRST = 9'h00c;
  localparam logic [8:0] LEN_LAST = 9'h01c;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] EXT_EWEN = 2'h3;
  localparam logic [1:0] EXT_EWDS = 2'h0;
  localparam logic [47:0] MAC_DEFAULT = 48'h0;
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] BUSY_TIMEOUT = 16'hffff;
  typedef enum logic [2:0] {
    L_IDLE = 3'h0, L_CS = 3'h1, L_SHIFT = 3'h3, L_READ = 3'h2,
    L_WAIT = 3'h6, L_DONE = 3'h7
  } link_state_t;
endpackage
`default_nettype wire

// file: rom_model.sv
// Purpose: Behavioural 3-wire byte-wide serial memory, 512 bytes
// Assumes: Bits sampled on rising rom_clk, data out on falling edge
// Notes: Outside a read the output toggles, except with cs high and no command started, where it shows ready (busy count zero)
`timescale 1ns/1ps
`default_nettype none
module rom_model (
  input wire logic rom_clk,
  input wire logic rom_cs,
  input wire logic rom_di,
  input wire logic blank,
  output logic rom_do
);
  logic [7:0] mem [0:511];
  logic [19:0] sh;
  logic [1:0] op;
  logic [8:0] a;
  logic [7:0] rdat;
  logic wen;
  int n;
  int busy;
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    mem[0] = 8'ha5;
    for (int i = 1; i < 7; i++) mem[i] = 8'(i * 17);
    // Zero lengths mark absent items; one item is left present
    for (int i = 12; i < 29; i++) mem[i] = 8'h00;
    mem[14] = 8'h04;
    mem[9'h100] = 8'h5a;
    rom_do = 1'b0;
    n = 0;
    busy = 0;
    wen = 1'b0;
    sh = '0;
  end
  always @(posedge rom_clk) begin
    if (busy > 0) busy--;
    if (!rom_cs) begin
      n = 0;
    end else if (n != 0 || rom_di) begin
      sh = {sh[18:0], rom_di};
      n++;
      if (n == 12) begin
        op = sh[10:9];
        a = sh[8:0];
        rdat = (blank && a == 9'h000) ? 8'hff : mem[a];
        if (op == 2'h0 && sh[8:7] == 2'h3) wen = 1'b1;
        if (op == 2'h0 && sh[8:7] == 2'h0) wen = 1'b0;
        if (op == 2'h3 && wen) begin
          mem[a] = 8'hff;
          busy = 20;
        end
      end
      if (n == 20 && op == 2'h1 && wen) begin
        mem[a] = sh[7:0];
        busy = 20;
      end
    end
  end
  always @(negedge rom_clk) begin
    if (rom_cs && n >= 12 && n < 20 && op == 2'h2) rom_do <= rdat[19-n];
    else if (rom_cs && n == 0) rom_do <= (busy == 0);
    else rom_do <= ~rom_do;
  end
endmodule // rom_model
`default_nettype wire

// file: serial_rom_controller.sv
// Purpose: Power-up loader and host access engine for a 3-wire serial ROM
// Assumes: Link logic on rom_clk domain; host and load logic on sys_clk
// Notes: Read bytes cross by toggle handshake into a 16-word FIFO on sys_clk
//
// Contract
// - Nine address bits go out on the link for 256 or 512 byte parts.
// - The part is byte organized and every transfer is eight bits.
// - After each reset the defaults are fetched from a valid part.
// - Host USB traffic is held off until the fetch has finished.
// - The fetched station address lands in the high and low address registers.
// - The host can read, write and erase the part.
// - A zero length field means the item is absent and defaults apply.
`timescale 1ns/1ps
`default_nettype none
module serial_rom_controller #(
  parameter int FIFO_D = config_loader_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rom_clk,
  output logic rom_cs,
  output logic rom_di,
  input wire logic rom_do,
  output logic usb_gate_open,
  output logic [15:0] station_addr_high_reg,
  output logic [31:0] station_addr_low_reg,
  output logic rom_valid,
  output logic cfg_we,
  output logic [8:0] cfg_addr,
  output logic [7:0] cfg_data,
  input wire logic host_req,
  output logic host_ack,
  input wire logic [1:0] host_op,
  input wire logic [8:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic host_rvalid,
  input wire logic host_rready,
  output logic [7:0] host_rdata
);
  typedef enum logic [2:0] {
    M_LOAD_REQ = 3'h0, M_LOAD_WAIT = 3'h1, M_IDLE = 3'h3,
    M_HOST_WAIT = 3'h2, M_EN_WAIT = 3'h6, M_DIS_WAIT = 3'h7
  } main_state_t;
  typedef struct packed {
    main_state_t st;
    logic [8:0] addr;
    logic [47:0] mac;
    logic [15:0] ah;
    logic [31:0] al;
    logic valid;
    logic gate;
    logic req_tog;
    logic [1:0] op;
    logic [10:0] bits_cmd;
    logic [7:0] wd;
    logic ack;
    logic we;
    logic [8:0] waddr;
    logic [7:0] wdat;
    logic [2:0] done_sync;
  } sys_st_t;
  typedef struct packed {
    config_loader_pkg::link_state_t st;
    logic [1:0] req_sync;
    logic req_seen;
    logic [4:0] cnt;
    logic [25:0] sh;
    logic rd;
    logic wr;
    logic er;
    logic [7:0] rx;
    logic cs;
    logic di;
    logic done_tog;
    logic [1:0] do_sync;
  } link_st_t;
  sys_st_t s, next_s;
  link_st_t l, next_l;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic link_done, host_phase;
  // Read answers reach the host only in its own read phase
  assign host_phase = s.st == M_HOST_WAIT;
  assign link_done = s.done_sync[2] != s.done_sync[1];
  always_comb begin
    next_s = s;
    next_s.done_sync = {s.done_sync[1:0], l.done_tog};
    next_s.ack = 1'b0;
    next_s.we = 1'b0;
    case (s.st)
      M_LOAD_REQ: begin
        next_s.op = config_loader_pkg::OP_READ;
        next_s.req_tog = !s.req_tog;
        next_s.st = M_LOAD_WAIT;
      end
      M_LOAD_WAIT: begin
        if (fifo_out_valid) begin
          next_s.addr = s.addr + 9'h001;
          next_s.st = M_LOAD_REQ;
          if (s.addr == config_loader_pkg::SIG_OFF) begin
            next_s.valid = fifo_out_data == config_loader_pkg::SIG_BYTE;
            if (fifo_out_data != config_loader_pkg::SIG_BYTE) begin
              next_s.st = M_IDLE;
              next_s.gate = 1'b1;
            end
          end else begin
            if (s.addr <= config_loader_pkg::MAC_LAST)
              next_s.mac[(s.addr - 9'h001) * 8 +: 8] = fifo_out_data;
            if (s.addr >= config_loader_pkg::LEN_FIRST &&
                s.addr <= config_loader_pkg::LEN_LAST && !s.addr[0]) begin
              next_s.we = fifo_out_data != 8'h00;
            end else begin
              next_s.we = 1'b1;
            end
            next_s.waddr = s.addr;
            next_s.wdat = fifo_out_data;
            if (s.addr == config_loader_pkg::MAC_LAST) begin
              next_s.ah = {fifo_out_data, s.mac[39:32]};
              next_s.al = s.mac[31:0];
            end
            if (s.addr == config_loader_pkg::LOAD_LAST) begin
              next_s.gate = 1'b1;
              next_s.st = M_IDLE;
            end
          end
        end
      end
      M_IDLE: begin
        if (host_req && fifo_in_ready) begin
          next_s.ack = 1'b1;
          next_s.addr = host_addr;
          next_s.wd = host_wdata;
          if (host_op == config_loader_pkg::OP_READ) begin
            next_s.op = host_op;
            next_s.req_tog = !s.req_tog;
            next_s.st = M_HOST_WAIT;
          end else begin
            next_s.op = config_loader_pkg::OP_EXT;
            next_s.addr = {config_loader_pkg::EXT_EWEN, 7'h00};
            next_s.bits_cmd = {host_op, host_addr};
            next_s.req_tog = !s.req_tog;
            next_s.st = M_EN_WAIT;
          end
        end
      end
      M_HOST_WAIT: begin
        if (fifo_out_valid && host_rready) next_s.st = M_IDLE;
      end
      M_EN_WAIT: begin
        if (link_done) begin
          next_s.op = s.bits_cmd[10:9];
          next_s.addr = s.bits_cmd[8:0];
          next_s.req_tog = !s.req_tog;
          next_s.st = M_DIS_WAIT;
        end
      end
      default: begin
        if (link_done) begin
          if (s.op != config_loader_pkg::OP_EXT) begin
            next_s.op = config_loader_pkg::OP_EXT;
            next_s.addr = {config_loader_pkg::EXT_EWDS, 7'h00};
            next_s.req_tog = !s.req_tog;
          end else begin
            next_s.st = M_IDLE;
          end
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.ah <= config_loader_pkg::MAC_DEFAULT[47:32];
      s.al <= config_loader_pkg::MAC_DEFAULT[31:0];
    end else begin
      s <= next_s;
    end
  end
  // Link side; command fields are stable while the request toggle crosses
  always_comb begin
    next_l = l;
    next_l.req_sync = {l.req_sync[0], s.req_tog};
    next_l.do_sync = {l.do_sync[0], rom_do};
    case (l.st)
      config_loader_pkg::L_IDLE: begin
        next_l.cs = 1'b0;
        if (l.req_sync[1] != l.req_seen) begin
          next_l.req_seen = l.req_sync[1];
          next_l.rd = s.op == config_loader_pkg::OP_READ;
          next_l.wr = s.op == config_loader_pkg::OP_WRITE;
          next_l.er = s.op == config_loader_pkg::OP_ERASE;
          next_l.sh = {1'b1, s.op, s.addr, s.wd, 6'h00};
          next_l.cnt = s.op == config_loader_pkg::OP_WRITE ? 5'd20 : 5'd12;
          next_l.cs = 1'b1;
          next_l.st = config_loader_pkg::L_SHIFT;
        end
      end
      config_loader_pkg::L_SHIFT: begin
        next_l.di = l.sh[25];
        next_l.sh = {l.sh[24:0], 1'b0};
        next_l.cnt = l.cnt - 5'd1;
        if (l.cnt == 5'd1) begin
          // Registered pin and two sync flops delay the first data bit
          next_l.cnt = l.rd ? 5'd11 : 5'd10;
          if (l.rd) next_l.st = config_loader_pkg::L_READ;
          else if (l.wr || l.er)
            next_l.st = config_loader_pkg::L_CS;
          else next_l.st = config_loader_pkg::L_DONE;
        end
      end
      config_loader_pkg::L_READ: begin
        next_l.di = 1'b0;
        next_l.rx = {l.rx[6:0], l.do_sync[1]};
        next_l.cnt = l.cnt - 5'd1;
        if (l.cnt == 5'd1) next_l.st = config_loader_pkg::L_DONE;
      end
      config_loader_pkg::L_CS: begin
        next_l.cs = 1'b0;
        next_l.di = 1'b0;
        next_l.cnt = l.cnt - 5'd1;
        if (l.cnt == 5'd1) begin
          // Skip samples still in the synchroniser from the deselected pin
          next_l.cnt = 5'd2;
          next_l.cs = 1'b1;
          next_l.st = config_loader_pkg::L_WAIT;
        end
      end
      config_loader_pkg::L_WAIT: begin
        if (l.cnt != 5'd0) next_l.cnt = l.cnt - 5'd1;
        else if (l.do_sync[1]) next_l.st = config_loader_pkg::L_DONE;
      end
      default: begin
        next_l.cs = 1'b0;
        next_l.di = 1'b0;
        next_l.done_tog = !l.done_tog;
        next_l.st = config_loader_pkg::L_IDLE;
      end
    endcase
  end
  always_ff @(posedge rom_clk) begin
    if (!rst_n) l <= '0;
    else l <= next_l;
  end
  // Byte in l.rx holds still from the done toggle until the next request
  assign fifo_in_valid = link_done && (s.st == M_LOAD_WAIT || host_phase);
  assign fifo_out_ready = host_phase ? host_rready : (s.st == M_LOAD_WAIT);
  cfg_fifo #(.WIDTH(8), .DEPTH(FIFO_D)) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(l.rx),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  assign rom_cs = l.cs;
  assign rom_di = l.di;
  assign usb_gate_open = s.gate;
  assign station_addr_high_reg = s.ah;
  assign station_addr_low_reg = s.al;
  assign rom_valid = s.valid;
  assign cfg_we = s.we;
  assign cfg_addr = s.waddr;
  assign cfg_data = s.wdat;
  assign host_ack = s.ack;
  assign host_rvalid = host_phase && fifo_out_valid;
  assign host_rdata = fifo_out_data;
  property p_gate_closed_loading;
    @(posedge sys_clk) disable iff (!rst_n)
      (s.st == M_LOAD_WAIT || s.st == M_LOAD_REQ) |-> !usb_gate_open;
  endproperty
  a_gate_closed_loading: assert property (p_gate_closed_loading)
    else $error("gate open during load");
  property p_ack_only_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      host_ack |-> $past(s.st) == M_IDLE;
  endproperty
  a_ack_only_idle: assert property (p_ack_only_idle)
    else $error("host ack outside idle");
  property p_ack_single;
    @(posedge sys_clk) disable iff (!rst_n)
      host_ack |=> !host_ack;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("host ack longer than one cycle");
  property p_rdata_held;
    @(posedge sys_clk) disable iff (!rst_n)
      (host_rvalid && !host_rready) |=> host_rvalid && $stable(host_rdata);
  endproperty
  a_rdata_held: assert property (p_rdata_held)
    else $error("read answer dropped before taken");
  property p_gate_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      usb_gate_open |=> usb_gate_open;
  endproperty
  a_gate_sticky: assert property (p_gate_sticky)
    else $error("gate closed again without reset");
  property p_station_high;
    @(posedge sys_clk) disable iff (!rst_n)
      (s.st == M_LOAD_WAIT && fifo_out_valid && s.addr == config_loader_pkg::MAC_LAST)
        |=> station_addr_high_reg[15:8] == $past(fifo_out_data);
  endproperty
  a_station_high: assert property (p_station_high)
    else $error("station address high byte not loaded");
  property p_zero_len_skipped;
    @(posedge sys_clk) disable iff (!rst_n)
      (cfg_we && cfg_addr >= config_loader_pkg::LEN_FIRST &&
        cfg_addr <= config_loader_pkg::LEN_LAST && !cfg_addr[0])
        |-> cfg_data != 8'h00;
  endproperty
  a_zero_len_skipped: assert property (p_zero_len_skipped)
    else $error("zero length field written");
  property p_read_eight_bits;
    @(posedge rom_clk) disable iff (!rst_n)
      $rose(l.st == config_loader_pkg::L_READ)
        |-> ##10 (l.st == config_loader_pkg::L_READ) ##1 (l.st == config_loader_pkg::L_DONE);
  endproperty
  a_read_eight_bits: assert property (p_read_eight_bits)
    else $error("read phase length wrong");
endmodule // serial_rom_controller
`default_nettype wire

// file: serial_rom_controller_test.sv
// Purpose: Self-checking bench for the serial ROM loader
// Assumes: rom_clk free running at 80 ns
// Notes: Host ops held until acknowledged, so busy periods serialise them
`timescale 1ns/1ps
`default_nettype none
module serial_rom_controller_test;
  logic sys_clk, rom_clk, rst_n, blank, host_req, host_rready;
  logic rom_cs, rom_di, rom_do, usb_gate_open, rom_valid, cfg_we, host_ack, host_rvalid;
  logic [1:0] host_op;
  logic [8:0] host_addr, cfg_addr;
  logic [7:0] host_wdata, host_rdata, cfg_data, rd;
  logic [15:0] station_addr_high_reg;
  logic [31:0] station_addr_low_reg;
  int err_total, check_count, we_count;
  // Rows: op, address, write data, expected read data
  localparam logic [26:0] ROWS [0:6] = '{{2'h1, 9'h040, 8'h3c, 8'h00},
    {2'h2, 9'h040, 8'h00, 8'h3c}, {2'h3, 9'h040, 8'h00, 8'h00},
    {2'h2, 9'h040, 8'h00, 8'hff}, {2'h1, 9'h1ff, 8'h81, 8'h00},
    {2'h2, 9'h1ff, 8'h00, 8'h81}, {2'h2, 9'h100, 8'h00, 8'h5a}};
  serial_rom_controller dut (.sys_clk(sys_clk), .rst_n(rst_n), .rom_clk(rom_clk),
    .rom_cs(rom_cs), .rom_di(rom_di), .rom_do(rom_do), .usb_gate_open(usb_gate_open),
    .station_addr_high_reg(station_addr_high_reg),
    .station_addr_low_reg(station_addr_low_reg), .rom_valid(rom_valid),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .host_req(host_req),
    .host_ack(host_ack), .host_op(host_op), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rvalid(host_rvalid), .host_rready(host_rready),
    .host_rdata(host_rdata));
  rom_model rom (.rom_clk(rom_clk), .rom_cs(rom_cs), .rom_di(rom_di), .blank(blank),
    .rom_do(rom_do));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    rom_clk = 1'b0;
    #13;
    forever #40 rom_clk = ~rom_clk;
  end
  always @(posedge sys_clk) if (cfg_we === 1'b1) we_count++;
  task automatic check_flag(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic check_data(input logic [47:0] got, input logic [47:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic host_xfer(input logic [1:0] op, input logic [8:0] a, input logic [7:0] d,
    output logic [7:0] r);
    int k;
    @(posedge sys_clk);
    host_req <= 1'b1;
    host_op <= op;
    host_addr <= a;
    host_wdata <= d;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (host_ack !== 1'b1 && k < 40000);
    check_flag(host_ack, 1'b1, "no host ack");
    host_req <= 1'b0;
    r = 8'hxx;
    if (op == 2'h2) begin
      k = 0;
      while (host_rvalid !== 1'b1 && k < 4000) begin @(posedge sys_clk); k++; end
      check_flag(host_rvalid, 1'b1, "no read answer");
      // Ready comes late so the answer has to stand for a cycle
      host_rready <= 1'b1;
      @(posedge sys_clk);
      r = host_rdata;
      host_rready <= 1'b0;
    end
  endtask
  task automatic load(input logic b);
    logic seen;
    int k;
    @(posedge sys_clk);
    blank <= b;
    rst_n <= 1'b0;
    // Long enough for two link clock edges as well
    repeat (40) @(posedge sys_clk);
    rst_n <= 1'b1;
    host_req <= 1'b1;
    host_op <= 2'h2;
    seen = 1'b0;
    we_count = 0;
    repeat (20) begin @(posedge sys_clk); if (host_ack === 1'b1) seen = 1'b1; end
    host_req <= 1'b0;
    check_flag(seen, 1'b0, "request taken while loading");
    check_flag(usb_gate_open, 1'b0, "gate open during load");
    k = 0;
    while (usb_gate_open !== 1'b1 && k < 50000) begin @(posedge sys_clk); k++; end
    check_flag(usb_gate_open, 1'b1, "gate never opened");
    check_flag(rom_valid, ~b, "signature flag");
    check_flag(we_count != 0, ~b, "config writes");
    // Blank part: address stays default, left to host software
    check_data({station_addr_high_reg, station_addr_low_reg},
      b ? config_loader_pkg::MAC_DEFAULT : 48'h665544332211, "station address");
    $display("load test done, blank=%0d", b);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    // Three loads of about 125 us at most plus host traffic
    #400000;
    err_total++;
    complete_run;
  end
  initial begin
    {rst_n, blank, host_req, host_rready, host_op, host_addr, host_wdata} = '0;
    err_total = 0;
    check_count = 0;
    load(1'b0);
    for (int i = 0; i < 7; i++) begin
      host_xfer(ROWS[i][26:25], ROWS[i][24:16], ROWS[i][15:8], rd);
      if (ROWS[i][26:25] == 2'h2) check_data(48'(rd), 48'(ROWS[i][7:0]), "read data");
    end
    $display("host access test done");
    load(1'b1);
    load(1'b0);
    complete_run;
  end
endmodule // serial_rom_controller_test
`default_nettype wire
